// ---- ado_pkg.sv ----
package ado_pkg;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned MAX_DEPTH       = 14;
  localparam int unsigned IDX_W           = 4;
  localparam int unsigned CNT_W           = 8;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // settling and delay, as counts
  localparam int unsigned SETTLE_CLKS     = 47;
  localparam int unsigned STEP_SETTLE_PER = 47;
  localparam int unsigned IMPULSE_PER     = 26;
  // decimation factors per data-rate setting
  localparam int unsigned DECIM_NORMAL    = 8;
  localparam int unsigned DECIM_DOUBLE    = 4;
  // period of a skipped burst
  localparam int unsigned SKIP_PERIOD     = 128;
  localparam logic [2:0]  DEPTH_OFF       = 3'h0;
  localparam logic [DATA_W-1:0] DOUT_RST  = 16'h0000;

  typedef enum logic [1:0] {
    ADO_ARMING  = 2'b00,
    ADO_RUN     = 2'b01,
    ADO_WAITRD  = 2'b10,
    ADO_FAULT   = 2'b11
  } ado_state_t;
endpackage

// ---- ado_stream_if.sv ----
`timescale 1ns/100ps
interface ado_stream_if;
  import ado_pkg::*;
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- ado_skid.sv ----
`timescale 1ns/100ps
module ado_skid
  import ado_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  ado_stream_if.snk up,
  ado_stream_if.src dn
);
  import ado_pkg::*;

  logic [DATA_W-1:0] slot_reg [2];
  logic [1:0]        cnt_reg;
  logic              head_reg;
  logic              push;
  logic              pop;

  assign up.ready = (cnt_reg != 2'd2);
  assign dn.valid = (cnt_reg != 2'd0);
  assign dn.data  = slot_reg[head_reg];
  assign push     = up.valid & up.ready;
  assign pop      = dn.valid & dn.ready;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 2'd0;
      head_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        head_reg <= ~head_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slot_reg[0] <= DOUT_RST;
      slot_reg[1] <= DOUT_RST;
    end else if (push) begin
      // tail is head plus occupancy, modulo two
      slot_reg[head_reg ^ cnt_reg[0]] <= up.data;
    end
  end
endmodule

// ---- ado_readout.sv ----
`timescale 1ns/100ps
module ado_readout
  import ado_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic [2:0]                buffer_depth_select,
  input  wire logic                      double_rate_select,
  output logic                           conv_strobe,
  input  wire logic [ado_pkg::DATA_W-1:0] filt_data,
  input  wire logic                      filt_valid,
  output logic                           filt_ready,
  input  wire logic                      cs_n,
  input  wire logic                      rd_n,
  output logic [ado_pkg::DATA_W-1:0]     dout,
  output logic                           dout_oe,
  output logic                           sample_ready_n,
  output logic                           filter_settled,
  output logic                           impulse_aligned,
  output logic                           readback_fault
);
  import ado_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // settling table
  function automatic logic [CNT_W-1:0] settle_periods(input logic [2:0] code);
    case (code)
      3'h1:    settle_periods = 8'd24;
      3'h2:    settle_periods = 8'd12;
      3'h3:    settle_periods = 8'd8;
      3'h4:    settle_periods = 8'd6;
      3'h5:    settle_periods = 8'd5;
      default: settle_periods = 8'd4;
    endcase
  endfunction

  logic             buf_on;
  logic [IDX_W-1:0] depth;
  logic [CNT_W-1:0] per_last;
  assign buf_on = (buffer_depth_select != DEPTH_OFF);
  // depth is 2n, unbuffered acts as depth one
  assign depth  = buf_on ? {buffer_depth_select, 1'b0} : 4'd1;
  // period is 16n clocks, eight when unbuffered
  assign per_last = buf_on ? ({1'b0, buffer_depth_select, 4'h0} - 8'h01) :
                    CNT_W'(DECIM_NORMAL - 1);

  // ---------------------------------------------------------------
  // decimation tick
  // ---------------------------------------------------------------
  logic [2:0] dec_reg;
  logic [2:0] dec_last;
  assign dec_last = double_rate_select ? 3'(DECIM_DOUBLE - 1) : 3'(DECIM_NORMAL - 1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_reg     <= 3'h0;
      conv_strobe <= 1'b0;
    end else begin
      conv_strobe <= (dec_reg >= dec_last);
      dec_reg     <= (dec_reg >= dec_last) ? 3'h0 : dec_reg + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // two-entry buffer in the sample path
  // ---------------------------------------------------------------
  ado_stream_if s_in ();
  ado_stream_if s_out ();
  assign s_in.valid = filt_valid;
  assign s_in.data  = filt_data;
  assign filt_ready = s_in.ready;

  ado_skid u_skid (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .up      (s_in),
    .dn      (s_out)
  );

  // ---------------------------------------------------------------
  // read strobe edges
  // ---------------------------------------------------------------
  logic rd_n_d;
  logic rd_fall;
  logic rd_rise;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_n_d <= 1'b1;
    end else begin
      rd_n_d <= rd_n;
    end
  end
  // strobe acts whatever chip select does
  assign rd_fall = rd_n_d & ~rd_n;
  assign rd_rise = ~rd_n_d & rd_n;

  // ---------------------------------------------------------------
  // storage: two banks, one filling while the other is read
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem_reg [2][MAX_DEPTH];
  logic              wbank_reg;
  logic [IDX_W-1:0]  widx_reg;
  logic [IDX_W-1:0]  ridx_reg;
  logic [CNT_W-1:0]  gap_reg;
  logic [IDX_W-1:0]  rdepth_reg;
  logic              period_end;
  logic              burst_full;
  logic              skip_wait;
  logic              hand_over;
  logic              bad_count;
  ado_state_t        state_reg;

  assign burst_full = (widx_reg >= depth);
  // hand over only once the period has run
  // a backlog refills a bank early; judging reads then would fault a host mid-burst
  assign period_end = burst_full & (gap_reg >= per_last);
  // buffered and nothing read: hold the burst until the stretched period ends
  assign skip_wait  = buf_on & (ridx_reg == '0) & (gap_reg < CNT_W'(SKIP_PERIOD - 1));
  // reads judged against the depth of the burst being read
  assign bad_count  = buf_on & (ridx_reg != '0) & (ridx_reg != rdepth_reg);
  assign hand_over  = period_end & (state_reg == ADO_RUN) & ~skip_wait & ~bad_count;
  // writes stall while a full bank waits; the skid buffer absorbs two words, then stalls the source
  assign s_out.ready = (state_reg == ADO_RUN) & ~burst_full;

  always_ff @(posedge ref_clk) begin
    if (s_out.valid & s_out.ready) begin
      mem_reg[wbank_reg][widx_reg] <= s_out.data;
    end
  end

  // buffered mode waits for a read pulse after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ADO_ARMING;
    end else begin
      case (state_reg)
        ADO_ARMING: begin
          if (!buf_on || rd_rise) begin
            state_reg <= ADO_RUN;
          end
        end
        ADO_RUN: begin
          if (period_end && bad_count) begin
            state_reg <= ADO_FAULT;
          end
        end
        ADO_FAULT:  state_reg <= ADO_FAULT;
        default:    state_reg <= ADO_ARMING;
      endcase
    end
  end

  // count results, then announce the burst
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      widx_reg       <= '0;
      wbank_reg      <= 1'b0;
      gap_reg        <= '0;
      sample_ready_n <= 1'b1;
    end else begin
      sample_ready_n <= (state_reg == ADO_ARMING) ? 1'b1 : hand_over;
      if (hand_over) begin
        widx_reg  <= '0;
        wbank_reg <= ~wbank_reg;
        gap_reg   <= '0;
      end else begin
        if (s_out.valid && s_out.ready) begin
          widx_reg <= widx_reg + 4'd1;
        end
        if (gap_reg != '1) begin
          gap_reg <= gap_reg + 8'd1;
        end
      end
    end
  end

  // first fall shows the oldest; each later fall the next
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ridx_reg   <= '0;
      rdepth_reg <= 4'd1;
      dout       <= DOUT_RST;
    end else if (hand_over) begin
      // new burst reads from its oldest entry
      ridx_reg   <= '0;
      // a live depth change leaves the pending burst's count alone
      rdepth_reg <= depth;
    end else if (rd_fall && state_reg != ADO_ARMING) begin
      dout     <= mem_reg[~wbank_reg][ridx_reg];
      // excess reads are counted one past depth and, when buffered, caught as a fault
      if (ridx_reg <= rdepth_reg) begin
        ridx_reg <= ridx_reg + 4'd1;
      end
    end
  end

  // bus drives only with both strobes low
  assign dout_oe        = ~cs_n & ~rd_n;
  assign readback_fault = (state_reg == ADO_FAULT);

  // ---------------------------------------------------------------
  // settling
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] clk_cnt_reg;
  logic [CNT_W-1:0] per_cnt_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_cnt_reg <= '0;
      per_cnt_reg <= '0;
    end else begin
      if (clk_cnt_reg != '1) begin
        clk_cnt_reg <= clk_cnt_reg + 8'd1;
      end
      if (hand_over && per_cnt_reg != '1) begin
        per_cnt_reg <= per_cnt_reg + 8'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filter_settled  <= 1'b0;
      impulse_aligned <= 1'b0;
    end else begin
      // clocks since reset; periods per depth; unbuffered periods
      filter_settled <= buf_on ?
        (clk_cnt_reg >= CNT_W'(SETTLE_CLKS)) &&
        (per_cnt_reg >= settle_periods(buffer_depth_select)) :
        (per_cnt_reg >= CNT_W'(STEP_SETTLE_PER));
      // group delay of the impulse peak
      impulse_aligned <= ~buf_on && (per_cnt_reg >= CNT_W'(IMPULSE_PER));
    end
  end
endmodule

// ---- ado_src_model.sv ----
`timescale 1ns/100ps
module ado_src_model
  import ado_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       conv_strobe,
  input  wire logic                       filt_ready,
  output logic                            filt_valid,
  output logic [ado_pkg::DATA_W-1:0]      filt_data
);
  // ----
  // counting sample source
  // ----
  logic [DATA_W-1:0] cnt_reg;
  // an idle bus shows the inverse, so a stale word never passes for data
  assign filt_data = filt_valid ? cnt_reg : ~cnt_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filt_valid <= 1'b0;
      cnt_reg    <= 16'h0000;
    end else if (conv_strobe && !(filt_valid && !filt_ready)) begin
      filt_valid <= 1'b1;
      cnt_reg    <= cnt_reg + 16'h0001;
    end else if (filt_ready) begin
      filt_valid <= 1'b0;
    end
  end
endmodule

// ---- ado_readout_assertions.sv ----
`timescale 1ns/100ps
module ado_readout_chk
  import ado_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [2:0] buffer_depth_select,
  input wire logic       double_rate_select,
  input wire logic       conv_strobe,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       dout_oe,
  input wire logic       sample_ready_n,
  input wire logic       filter_settled,
  input wire logic       impulse_aligned,
  input wire logic       readback_fault
);
  // ----
  // cycles since reset release
  // ----
  logic [7:0] cyc_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cyc_reg <= 8'h00;
    else if (cyc_reg != 8'hff) cyc_reg <= cyc_reg + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_oe; dout_oe == (!cs_n && !rd_n); endproperty
  a_oe: assert property (p_oe)
    else $error("bus enable does not follow select and read");
  property p_pulse; $rose(sample_ready_n) |=> !sample_ready_n; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready pulse longer than one cycle");
  property p_per0; $rose(sample_ready_n) && buffer_depth_select == 3'h0 |-> ##8 sample_ready_n;
  endproperty
  a_per0: assert property (p_per0)
    else $error("unbuffered ready period not eight");
  property p_conv;
    conv_strobe && !double_rate_select |=> !conv_strobe [*7] ##1 conv_strobe;
  endproperty
  a_conv: assert property (p_conv)
    else $error("sample strobe not every eight clocks");
  property p_conv2;
    conv_strobe && double_rate_select |=> !conv_strobe [*3] ##1 conv_strobe;
  endproperty
  a_conv2: assert property (p_conv2)
    else $error("sample strobe not every four clocks at double rate");
  property p_sticky; readback_fault |=> readback_fault; endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault cleared without reset");
  property p_stall; readback_fault |-> !sample_ready_n; endproperty
  a_stall: assert property (p_stall)
    else $error("ready pulsed while faulted");
  property p_settle; $rose(filter_settled) && buffer_depth_select != 3'h0 |-> cyc_reg >= 46;
  endproperty
  a_settle: assert property (p_settle)
    else $error("buffered filter settled too early");
  property p_imp; impulse_aligned |-> buffer_depth_select == 3'h0; endproperty
  a_imp: assert property (p_imp)
    else $error("impulse flag raised while buffered");
  c_fault: cover property (readback_fault);
  c_deep: cover property ($rose(sample_ready_n) && buffer_depth_select == 3'h7);
  c_settle: cover property ($rose(filter_settled));
endmodule
bind ado_readout ado_readout_chk u_chk (.ref_clk, .nrst, .buffer_depth_select,
  .double_rate_select, .conv_strobe, .cs_n, .rd_n, .dout_oe, .sample_ready_n,
  .filter_settled, .impulse_aligned, .readback_fault);

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import ado_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              cs_n = 1'b1;
  logic              rd_n = 1'b1;
  logic              double_rate_select = 1'b0;
  logic [2:0]        buffer_depth_select = 3'h0;
  logic              conv_strobe, filt_valid, filt_ready, dout_oe, sample_ready_n;
  logic              filter_settled, impulse_aligned, readback_fault;
  logic [DATA_W-1:0] filt_data, dout, last;
  int                n_fail = 0, comparisons = 0, cyc = 0, t0, t1, n;
  // code, ready period, depth, settling in ready periods
  int rows [8][4] = '{'{0,8,1,47}, '{1,16,2,24}, '{2,32,4,12}, '{3,48,6,8},
                      '{4,64,8,6}, '{5,80,10,5}, '{6,96,12,4}, '{7,112,14,4}};
  always #(CLK_PERIOD_NS/2) ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  ado_readout u_ado_readout (.ref_clk, .nrst, .buffer_depth_select, .double_rate_select,
    .conv_strobe, .filt_data, .filt_valid, .filt_ready, .cs_n, .rd_n, .dout, .dout_oe,
    .sample_ready_n, .filter_settled, .impulse_aligned, .readback_fault);
  ado_src_model u_ado_src_model (.ref_clk, .nrst, .conv_strobe, .filt_ready, .filt_valid,
    .filt_data);
  // ----
  // tasks
  // ----
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [2:0] c);
    nrst = 1'b0;
    buffer_depth_select = c;
    repeat (16) @(negedge ref_clk);
    cmp_val(sample_ready_n, 1'b1);
    nrst = 1'b1;
    @(negedge ref_clk);
    rd_n = 1'b0;
    @(negedge ref_clk);
    rd_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic wait_pulse(output int t);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (sample_ready_n !== 1'b1 && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    t = cyc;
  endtask
  // clocks between two sample strobes
  task automatic strobe_gap(output int t);
    int a;
    a = 0;
    while (conv_strobe !== 1'b1 && a < 20) begin
      @(negedge ref_clk);
      a++;
    end
    t = cyc;
    @(negedge ref_clk);
    while (conv_strobe !== 1'b1 && a < 40) begin
      @(negedge ref_clk);
      a++;
    end
    t = cyc - t;
  endtask
  // chg, when nonzero, is the depth code applied between first and last word
  // strobes clock-aligned, selected
  task automatic read_burst(input int d, input logic chk, input logic [2:0] chg);
    for (int i = 0; i < d; i++) begin
      cs_n = 1'b0;
      rd_n = 1'b0;
      @(negedge ref_clk);
      cmp_val(dout_oe, 1'b1);
      @(negedge ref_clk);
      if (chk) cmp_val(dout, last + 16'h0001);
      last = dout;
      chk = 1'b1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      @(negedge ref_clk);
      cmp_val(dout_oe, 1'b0);
      if (i == 0 && chg != 3'h0) buffer_depth_select = chg;
    end
  endtask
  // ----
  // sequence
  // ----
  initial begin
    @(negedge ref_clk);
    foreach (rows[r]) begin
      do_reset(3'(rows[r][0]));
      n = 0;
      t0 = 0;
      while (n < 60) begin
        wait_pulse(t1);
        if (n > 0) cmp_cnt(t1 - t0, rows[r][1]);
        t0 = t1;
        n++;
        // the settled flag follows the period count by one clock
        @(negedge ref_clk);
        if (filter_settled === 1'b1) break;
        read_burst(rows[r][2], n > 1, 3'h0);
      end
      cmp_cnt(n, rows[r][3]);
      cmp_val(impulse_aligned, rows[r][0] == 0);
      read_burst(rows[r][2], 1'b0, 3'h0);
    end
    // skipped burst, live depth change, short read, then recovery
    do_reset(3'h1);
    wait_pulse(t0);
    read_burst(2, 1'b0, 3'h0);
    wait_pulse(t1);
    cmp_cnt(t1 - t0, 16);
    wait_pulse(t0);
    cmp_cnt(t0 - t1, SKIP_PERIOD);
    read_burst(2, 1'b0, 3'h2);
    wait_pulse(t1);
    cmp_cnt(t1 - t0, 32);
    read_burst(3, 1'b1, 3'h0);
    repeat (100) @(negedge ref_clk);
    cmp_val(readback_fault, 1'b1);
    cmp_val(sample_ready_n, 1'b0);
    cmp_val(filt_ready, 1'b0);
    do_reset(3'h2);
    wait_pulse(t0);
    cmp_val(readback_fault, 1'b0);
    read_burst(4, 1'b0, 3'h0);
    strobe_gap(n);
    cmp_cnt(n, DECIM_NORMAL);
    // rate is switched while reset is still high, just before do_reset lowers it
    double_rate_select = 1'b1;
    do_reset(3'h0);
    strobe_gap(n);
    cmp_cnt(n, DECIM_DOUBLE);
    close_out();
  end
  // longest run is some 5000 clocks; this span leaves ample margin
  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    close_out();
  end
endmodule
